//--- rtl/rss_defs.svh
// Constants for the reset source sequencer.
// Assumes a 25 MHz core clock and included by bare name.
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

`define RSS_CLK_HZ 25000000
`define RSS_POWER_UP_DELAY_TIMER_MS 72
`define RSS_POWER_UP_DELAY_TIMER_CYC ((`RSS_CLK_HZ / 1000) * `RSS_POWER_UP_DELAY_TIMER_MS)
`define RSS_POWER_UP_DELAY_TIMER_W 22
`define RSS_OST_CYC 1024
`define RSS_OST_W 11
`define RSS_MASTER_CLEAR_PIN_FILT 8
`define RSS_MASTER_CLEAR_PIN_FW 4

`define RSS_OSC_RC 2'h3
`define RSS_OSC_HS 2'h2
`define RSS_OSC_XT 2'h1
`define RSS_OSC_LP 2'h0

`define RSS_CAUSE_W 6
`define RSS_CAUSE_POR 0
`define RSS_CAUSE_BOR 1
`define RSS_CAUSE_MASTER_CLEAR_PIN_RUN 2
`define RSS_CAUSE_MASTER_CLEAR_PIN_SLP 3
`define RSS_CAUSE_WDT_RST 4
`define RSS_CAUSE_WDT_WAKE 5
`define RSS_CAUSE_RST 6'h01

`define RSS_A_CAUSE 4'h0
`define RSS_A_STAT 4'h1
`define RSS_A_CLR 4'h2
`define RSS_A_EN 4'h3
`define RSS_A_STATE 4'h4

`endif

//--- rtl/rss_pkg.sv
// Types for the reset source sequencer.
// Assumes rss_defs.svh supplies the numeric constants.
package rss_pkg;
   typedef enum logic [1:0] {
      RSS_LP, RSS_XT, RSS_HS, RSS_RC
   } rss_osc_t;

   typedef struct packed {
      logic [1:0] osc_sel;
      logic power_up_delay_timer_en_b;
      logic bor_en;
   } rss_cfg_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rss_bus_t;

   typedef enum logic [2:0] {
      RSS_ST_HOLD, RSS_ST_POWER_UP_DELAY_TIMER, RSS_ST_OST, RSS_ST_RUN
   } rss_state_t;
endpackage : rss_pkg

//--- rtl/rss_reset_seq.sv
// Reset source sequencer: classifies resets, runs the delay timers.
// Assumes async analog detectors drive i_por and i_bor and software uses the plain bus.
//
// Function
// - An external square clock is accepted on the oscillator input only in high speed mode.
// - Power-on and brown-out are power-up class, master clear and watchdog are not.
// - The keep-class registers are undefined after power-up resets and held on others.
// - Other registers get initial values on any reset except the sleep watchdog wake.
// - A watchdog timeout in sleep is a wake-up with no register reinitialisation.
// - Software can read which source caused the latest reset.
// - Short low pulses on the master clear pin are filtered out.
// - A watchdog reset never drives the master clear pin low.
// - A power-on pulse is made when the supply rises through the detector threshold.
// - After power-on the two delay timers hold the core in reset per configuration.
// - Oscillator select 11 is RC, 10 high speed, 01 crystal and 00 low power crystal.
// - The power-up delay timer runs its nominal delay only after power-up resets.
// - The startup timer counts oscillator cycles after the power-up delay in crystal modes.
// - The timer enable bit governs the power-up delay only for power-on, not brown-out.
`timescale 1ns/100ps
`include "rss_defs.svh"

module rss_reset_seq
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Reset sources
   input wire logic i_master_clear_pin_b,
   input wire logic i_por,
   input wire logic i_bor,
   input wire logic i_wdt_timeout,
   input wire logic i_sleep,
   input wire logic i_osc_clk,
   input wire logic i_ext_clk_sel,
   // Configuration
   input wire rss_pkg::rss_cfg_t i_cfg,
   // Register port
   input wire rss_pkg::rss_bus_t i_bus,
   output logic [7:0] o_rdata,
   // Core controls
   output logic o_core_rst,
   output logic o_init_regs,
   output logic o_undef_regs,
   output logic o_wake,
   output logic o_osc_ext_ok,
   output logic o_master_clear_pin_oe,
   output logic o_master_clear_pin_o,
   output logic o_irq
);
   import rss_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [2:0] master_clear_pin_s_q, master_clear_pin_s_d, por_s_q, por_s_d, bor_s_q, bor_s_d, osc_s_q, osc_s_d;
   always_comb
   begin
      master_clear_pin_s_d = {master_clear_pin_s_q[1:0], i_master_clear_pin_b};
      por_s_d = {por_s_q[1:0], i_por};
      bor_s_d = {bor_s_q[1:0], i_bor};
      osc_s_d = {osc_s_q[1:0], i_osc_clk};
   end
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         master_clear_pin_s_q <= 3'h7;
         // Supply detector reads high once the reset is over
         por_s_q <= 3'h7;
         bor_s_q <= 3'h0;
         osc_s_q <= 3'h0;
      end
      else
      begin
         master_clear_pin_s_q <= master_clear_pin_s_d;
         por_s_q <= por_s_d;
         bor_s_q <= bor_s_d;
         osc_s_q <= osc_s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Filtered levels
   logic master_clear_pin_lv_q, master_clear_pin_lv_d, por_lv_q, por_lv_d, bor_lv_q, bor_lv_d, osc_lv_q, osc_lv_d;
   logic [`RSS_MASTER_CLEAR_PIN_FW-1:0] mf_cnt_q, mf_cnt_d;
   logic master_clear_pin_low_q, master_clear_pin_low_d;
   logic osc_tick;
   always_comb
   begin
      master_clear_pin_lv_d = (master_clear_pin_s_q[1] == master_clear_pin_s_q[2]) ? master_clear_pin_s_q[2] : master_clear_pin_lv_q;
      por_lv_d = (por_s_q[1] == por_s_q[2]) ? por_s_q[2] : por_lv_q;
      bor_lv_d = (bor_s_q[1] == bor_s_q[2]) ? bor_s_q[2] : bor_lv_q;
      osc_lv_d = (osc_s_q[1] == osc_s_q[2]) ? osc_s_q[2] : osc_lv_q;
      master_clear_pin_low_d = master_clear_pin_low_q;
      mf_cnt_d = mf_cnt_q;
      if (master_clear_pin_lv_q)
      begin
         mf_cnt_d = '0;
         master_clear_pin_low_d = 1'b0;
      end
      else if (mf_cnt_q == `RSS_MASTER_CLEAR_PIN_FW'(`RSS_MASTER_CLEAR_PIN_FILT))
         master_clear_pin_low_d = 1'b1;
      else
         mf_cnt_d = mf_cnt_q + `RSS_MASTER_CLEAR_PIN_FW'(1);
   end
   assign osc_tick = osc_lv_d & ~osc_lv_q;
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         master_clear_pin_lv_q <= 1'b1;
         por_lv_q <= 1'b1;
         bor_lv_q <= 1'b0;
         osc_lv_q <= 1'b0;
         mf_cnt_q <= '0;
         master_clear_pin_low_q <= 1'b0;
      end
      else
      begin
         master_clear_pin_lv_q <= master_clear_pin_lv_d;
         por_lv_q <= por_lv_d;
         bor_lv_q <= bor_lv_d;
         osc_lv_q <= osc_lv_d;
         mf_cnt_q <= mf_cnt_d;
         master_clear_pin_low_q <= master_clear_pin_low_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Edge registers for power-on and master clear events
   logic master_clear_pin_prev_q, master_clear_pin_prev_d, por_prev_q, por_prev_d;
   always_comb
   begin
      master_clear_pin_prev_d = master_clear_pin_low_q;
      por_prev_d = por_lv_q;
   end
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         // Idle levels, so no false edge follows reset
         master_clear_pin_prev_q <= 1'b0;
         por_prev_q <= 1'b1;
      end
      else
      begin
         master_clear_pin_prev_q <= master_clear_pin_prev_d;
         por_prev_q <= por_prev_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   rss_state_t st_q, st_d;
   logic [`RSS_POWER_UP_DELAY_TIMER_W-1:0] pw_q, pw_d;
   logic [`RSS_OST_W-1:0] ost_q, ost_d;
   logic pwr_cls_q, pwr_cls_d, por_cls_q, por_cls_d;
   logic [`RSS_CAUSE_W-1:0] cause_q, cause_d, ev_q, ev_d, ien_q, ien_d;
   logic init_q, init_d, undef_q, undef_d, wake_q, wake_d;
   logic crystal, bor_act, por_pulse, wdt_rst, wdt_wake, src_act;
   logic [`RSS_CAUSE_W-1:0] set_ev, clr_ev;

   assign crystal = (i_cfg.osc_sel != `RSS_OSC_RC);
   assign o_osc_ext_ok = (i_cfg.osc_sel == `RSS_OSC_HS) | ~i_ext_clk_sel;
   assign por_pulse = por_lv_q & ~por_prev_q;
   assign bor_act = bor_lv_q & i_cfg.bor_en;
   assign wdt_rst = i_wdt_timeout & ~i_sleep & (st_q == RSS_ST_RUN);
   assign wdt_wake = i_wdt_timeout & i_sleep & (st_q == RSS_ST_RUN);
   assign src_act = master_clear_pin_low_q | por_pulse | bor_act | wdt_rst;

   always_comb
   begin
      st_d = st_q;
      pw_d = pw_q;
      ost_d = ost_q;
      pwr_cls_d = pwr_cls_q;
      por_cls_d = por_cls_q;
      cause_d = cause_q;
      init_d = 1'b0;
      undef_d = 1'b0;
      wake_d = 1'b0;
      set_ev = '0;
      if (por_pulse)
      begin
         pwr_cls_d = 1'b1;
         por_cls_d = 1'b1;
         set_ev[`RSS_CAUSE_POR] = 1'b1;
      end
      else if (bor_act & ~pwr_cls_q)
      begin
         pwr_cls_d = 1'b1;
         por_cls_d = 1'b0;
         set_ev[`RSS_CAUSE_BOR] = 1'b1;
      end
      else if (master_clear_pin_low_q & ~master_clear_pin_prev_q)
         set_ev[i_sleep ? `RSS_CAUSE_MASTER_CLEAR_PIN_SLP : `RSS_CAUSE_MASTER_CLEAR_PIN_RUN] = 1'b1;
      else if (wdt_rst)
         set_ev[`RSS_CAUSE_WDT_RST] = 1'b1;
      else if (wdt_wake)
         set_ev[`RSS_CAUSE_WDT_WAKE] = 1'b1;
      if (set_ev != '0)
         cause_d = set_ev;
      unique case (st_q)
         RSS_ST_HOLD:
         begin
            pw_d = '0;
            ost_d = '0;
            if (!src_act)
            begin
               if (pwr_cls_q & (~por_cls_q | ~i_cfg.power_up_delay_timer_en_b))
                  st_d = RSS_ST_POWER_UP_DELAY_TIMER;
               else if (pwr_cls_q & crystal)
                  st_d = RSS_ST_OST;
               else
                  st_d = RSS_ST_RUN;
            end
         end
         RSS_ST_POWER_UP_DELAY_TIMER:
         begin
            pw_d = pw_q + `RSS_POWER_UP_DELAY_TIMER_W'(1);
            if (src_act)
               st_d = RSS_ST_HOLD;
            else if (pw_q == `RSS_POWER_UP_DELAY_TIMER_W'(`RSS_POWER_UP_DELAY_TIMER_CYC - 1))
               st_d = crystal ? RSS_ST_OST : RSS_ST_RUN;
         end
         RSS_ST_OST:
         begin
            if (osc_tick)
               ost_d = ost_q + `RSS_OST_W'(1);
            if (src_act)
               st_d = RSS_ST_HOLD;
            else if (osc_tick & (ost_q == `RSS_OST_W'(`RSS_OST_CYC - 1)))
               st_d = RSS_ST_RUN;
         end
         RSS_ST_RUN:
         begin
            ost_d = '0;
            if (src_act)
               st_d = RSS_ST_HOLD;
            else if (wdt_wake & crystal)
               st_d = RSS_ST_OST;
            else if (wdt_wake)
               wake_d = 1'b1;
         end
         default: st_d = RSS_ST_HOLD;
      endcase
      if ((st_q == RSS_ST_OST) & (st_d == RSS_ST_RUN) & ~pwr_cls_q)
         wake_d = 1'b1;
      if ((st_q != RSS_ST_RUN) & (st_d == RSS_ST_RUN) & ~wake_d)
      begin
         init_d = 1'b1;
         undef_d = pwr_cls_q;
         pwr_cls_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status, enable and clear registers
   always_comb
   begin
      clr_ev = '0;
      ien_d = ien_q;
      if (i_bus.wr & (i_bus.addr == `RSS_A_CLR))
         clr_ev = i_bus.wdata[`RSS_CAUSE_W-1:0];
      if (i_bus.wr & (i_bus.addr == `RSS_A_EN))
         ien_d = i_bus.wdata[`RSS_CAUSE_W-1:0];
      ev_d = (ev_q & ~clr_ev) | set_ev;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         st_q <= RSS_ST_HOLD;
         pw_q <= '0;
         ost_q <= '0;
         pwr_cls_q <= 1'b1;
         por_cls_q <= 1'b1;
         cause_q <= `RSS_CAUSE_RST;
         ev_q <= `RSS_CAUSE_RST;
         ien_q <= '0;
         init_q <= 1'b0;
         undef_q <= 1'b0;
         wake_q <= 1'b0;
         o_rdata <= '0;
      end
      else
      begin
         st_q <= st_d;
         pw_q <= pw_d;
         ost_q <= ost_d;
         pwr_cls_q <= pwr_cls_d;
         por_cls_q <= por_cls_d;
         cause_q <= cause_d;
         ev_q <= ev_d;
         ien_q <= ien_d;
         init_q <= init_d;
         undef_q <= undef_d;
         wake_q <= wake_d;
         o_rdata <= '0;
         if (i_bus.rd)
         begin
            unique case (i_bus.addr)
               `RSS_A_CAUSE: o_rdata <= {2'h0, cause_q};
               `RSS_A_STAT: o_rdata <= {2'h0, ev_q};
               `RSS_A_EN: o_rdata <= {2'h0, ien_q};
               `RSS_A_STATE: o_rdata <= {5'h0, st_q};
               default: o_rdata <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   // core reset decoded from the state register
   assign o_core_rst = (st_q != RSS_ST_RUN);
   assign o_init_regs = init_q;
   assign o_undef_regs = undef_q;
   assign o_wake = wake_q;
   assign o_master_clear_pin_oe = 1'b0;
   assign o_master_clear_pin_o = 1'b0;
   assign o_irq = |(ev_q & ien_q);
endmodule : rss_reset_seq

//--- test/rss_reset_seq_sva.sv
// Port checker for the reset source sequencer.
// Assumes one clock domain; bound to every instance below.
`timescale 1ns/100ps
`include "rss_defs.svh"

module rss_reset_seq_sva
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Watched ports
   input wire logic i_master_clear_pin_b,
   input wire logic i_wdt_timeout,
   input wire logic i_sleep,
   input wire logic i_ext_clk_sel,
   input wire rss_pkg::rss_cfg_t i_cfg,
   input wire rss_pkg::rss_bus_t i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic o_core_rst,
   input wire logic o_init_regs,
   input wire logic o_undef_regs,
   input wire logic o_wake,
   input wire logic o_osc_ext_ok,
   input wire logic o_master_clear_pin_oe,
   input wire logic o_master_clear_pin_o,
   input wire logic o_irq
);
   import rss_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // Low long past sync and filter
   sequence s_long_low;
      (!i_master_clear_pin_b) [*8] ##1 (!i_master_clear_pin_b) [*8];
   endsequence
   pin_quiet_a: assert property (!o_master_clear_pin_oe && !o_master_clear_pin_o) else $error("pin driven");
   ext_clk_a: assert property (o_osc_ext_ok ==
      !(i_ext_clk_sel && i_cfg.osc_sel != `RSS_OSC_HS)) else $error("clock gate");
   long_low_a: assert property (s_long_low |-> o_core_rst) else $error("no reset");
   dog_rst_a: assert property (i_wdt_timeout && !i_sleep |-> ##[1:4] o_core_rst)
      else $error("no dog reset");
   dog_wake_a: assert property
      (i_wdt_timeout && i_sleep && i_cfg.osc_sel == `RSS_OSC_RC |-> ##[1:8] o_wake)
      else $error("no wake");
   undef_pair_a: assert property (o_undef_regs |-> o_init_regs) else $error("lone undef");
   init_pulse_a: assert property (o_init_regs |=> !o_init_regs) else $error("long init");
   rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == 8'h00) else $error("stray");
   irq_hold_a: assert property (o_irq && !i_bus.wr |=> o_irq) else $error("irq dropped");
endmodule : rss_reset_seq_sva

bind rss_reset_seq rss_reset_seq_sva u_sva (.i_clk, .i_rst_b, .i_master_clear_pin_b, .i_wdt_timeout,
   .i_sleep, .i_ext_clk_sel, .i_cfg, .i_bus, .o_rdata, .o_core_rst, .o_init_regs,
   .o_undef_regs, .o_wake, .o_osc_ext_ok, .o_master_clear_pin_oe, .o_master_clear_pin_o, .o_irq);

//--- test/rss_pins_model.sv
// Pin model: master clear, supply detectors, oscillator.
// Assumes the bench calls its tasks; oscillator runs free at 160 ns.
`timescale 1ns/100ps

module rss_pins_model
(
   // Core clock
   input wire logic i_clk,
   // Pins toward the block
   output logic o_master_clear_pin_b,
   output logic o_por,
   output logic o_bor,
   output logic o_osc_clk
);
   initial
   begin
      o_master_clear_pin_b = 1'b1;
      o_por = 1'b1;
      o_bor = 1'b0;
      o_osc_clk = 1'b0;
      #7;
      forever #80 o_osc_clk = ~o_osc_clk;
   end
   task automatic master_clear_pin_low(input int n);
      @(posedge i_clk);
      o_master_clear_pin_b <= 1'b0;
      repeat (n) @(posedge i_clk);
      o_master_clear_pin_b <= 1'b1;
   endtask : master_clear_pin_low
   task automatic por_low(input int n);
      @(posedge i_clk);
      o_por <= 1'b0;
      repeat (n) @(posedge i_clk);
      o_por <= 1'b1;
   endtask : por_low
   task automatic bor_high(input int n);
      @(posedge i_clk);
      o_bor <= 1'b1;
      repeat (n) @(posedge i_clk);
      o_bor <= 1'b0;
   endtask : bor_high
endmodule : rss_pins_model

//--- test/tb_rss_reset_seq.sv
// Bench for the reset source sequencer.
// Assumes the pin model and the bound checker sit beside the block.
`timescale 1ns/100ps
`include "rss_defs.svh"

module tb_rss_reset_seq;
   import rss_pkg::*;
   logic i_clk, i_rst_b, i_wdt_timeout, i_sleep, i_ext_clk_sel, master_clear_pin_b, por, bor, osc;
   logic o_core_rst, o_init_regs, o_undef_regs, o_wake, o_osc_ext_ok, o_irq;
   logic [7:0] o_rdata;
   rss_cfg_t i_cfg;
   rss_bus_t i_bus;
   int n_fail, samples_checked, n_init, n_undef, n_wake;
   ////////////////////////////////////////
   rss_reset_seq dut (.i_clk, .i_rst_b, .i_master_clear_pin_b(master_clear_pin_b), .i_por(por), .i_bor(bor),
      .i_wdt_timeout, .i_sleep, .i_osc_clk(osc), .i_ext_clk_sel, .i_cfg, .i_bus, .o_rdata,
      .o_core_rst, .o_init_regs, .o_undef_regs, .o_wake, .o_osc_ext_ok, .o_master_clear_pin_oe(),
      .o_master_clear_pin_o(), .o_irq);
   rss_pins_model u_pins (.i_clk, .o_master_clear_pin_b(master_clear_pin_b), .o_por(por), .o_bor(bor),
      .o_osc_clk(osc));
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      n_init <= n_init + o_init_regs;
      n_undef <= n_undef + o_undef_regs;
      n_wake <= n_wake + o_wake;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_bus <= '{a, v, 1'b1, 1'b0};
      @(posedge i_clk);
      i_bus <= '0;
      tick(1);
   endtask : bus_wr
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_clk);
      i_bus <= '0;
      #1;
      chk(o_rdata, e);
   endtask : rdc
   task automatic dog;
      @(posedge i_clk);
      i_wdt_timeout <= 1'b1;
      @(posedge i_clk);
      i_wdt_timeout <= 1'b0;
   endtask : dog
   task automatic do_reset;
      i_rst_b <= 1'b0;
      tick(20);
      n_init = 0;
      n_undef = 0;
      n_wake = 0;
      @(posedge i_clk);
      i_rst_b <= 1'b1;
   endtask : do_reset
   task automatic wait_run(input int lim);
      tick(5);
      for (int k = 0; k < lim && o_core_rst !== 1'b0; k++)
         tick(1);
      chk(o_core_rst, 1'b0);
      tick(2);
   endtask : wait_run
   ////////////////////////////////////////
   task automatic t_power_on;
      wait_run(60);
      tick(2);
      chk(n_undef, 1);
      chk(n_init, 1);
      rdc(`RSS_A_CAUSE, 8'h01);
      rdc(`RSS_A_STATE, 8'h03);
      i_ext_clk_sel <= 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         i_cfg.osc_sel <= m[1:0];
         tick(1);
         chk(o_osc_ext_ok, m == `RSS_OSC_HS);
      end
      i_ext_clk_sel <= 1'b0;
      i_cfg.osc_sel <= `RSS_OSC_RC;
      $display("%0t power-on end", $time);
   endtask : t_power_on
   task automatic t_irq;
      bus_wr(`RSS_A_EN, 8'h01);
      chk(o_irq, 1'b1);
      bus_wr(`RSS_A_EN, 8'h00);
      chk(o_irq, 1'b0);
      rdc(`RSS_A_STAT, 8'h01);
      bus_wr(`RSS_A_CLR, 8'h3f);
      bus_wr(`RSS_A_CAUSE, 8'hff);
      rdc(`RSS_A_STAT, 8'h00);
      rdc(`RSS_A_CAUSE, 8'h01);
      rdc(4'hf, 8'h00);
      bus_wr(`RSS_A_EN, 8'h3c);
      rdc(`RSS_A_EN, 8'h3c);
      $display("%0t irq end", $time);
   endtask : t_irq
   task automatic t_clear;
      u_pins.master_clear_pin_low(7);
      tick(20);
      chk(n_init, 1);
      u_pins.master_clear_pin_low(30);
      wait_run(60);
      chk(n_init, 2);
      chk(n_undef, 1);
      chk(o_irq, 1'b1);
      rdc(`RSS_A_CAUSE, 8'h04);
      i_sleep <= 1'b1;
      u_pins.master_clear_pin_low(30);
      wait_run(60);
      i_sleep <= 1'b0;
      rdc(`RSS_A_CAUSE, 8'h08);
      $display("%0t clear end", $time);
   endtask : t_clear
   task automatic t_dog;
      dog;
      wait_run(60);
      chk(n_init, 4);
      chk(n_undef, 1);
      rdc(`RSS_A_CAUSE, 8'h10);
      i_sleep <= 1'b1;
      dog;
      tick(10);
      i_sleep <= 1'b0;
      chk(n_wake, 1);
      chk(n_init, 4);
      rdc(`RSS_A_CAUSE, 8'h20);
      u_pins.por_low(10);
      wait_run(60);
      chk(n_undef, 2);
      rdc(`RSS_A_CAUSE, 8'h01);
      $display("%0t watchdog end", $time);
   endtask : t_dog
   task automatic t_ost;
      i_cfg.osc_sel <= `RSS_OSC_XT;
      do_reset;
      tick(3000);
      chk(o_core_rst, 1'b1);
      rdc(`RSS_A_STATE, 8'h02);
      wait_run(2000);
      i_sleep <= 1'b1;
      dog;
      tick(3000);
      chk(n_wake, 0);
      tick(1500);
      i_sleep <= 1'b0;
      chk(n_wake, 1);
      $display("%0t startup end", $time);
   endtask : t_ost
   task automatic t_bor;
      i_cfg <= '{`RSS_OSC_RC, 1'b1, 1'b0};
      do_reset;
      wait_run(60);
      i_cfg.bor_en <= 1'b1;
      u_pins.bor_high(10);
      tick(2000);
      chk(o_core_rst, 1'b1);
      rdc(`RSS_A_STATE, 8'h01);
      rdc(`RSS_A_CAUSE, 8'h02);
      $display("%0t brown-out end", $time);
   endtask : t_bor
   task automatic test_done;
      $display("%0d checks, %0d mismatches", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   ////////////////////////////////////////
   initial
   begin
      i_rst_b = 1'b0;
      i_wdt_timeout = 1'b0;
      i_sleep = 1'b0;
      i_ext_clk_sel = 1'b0;
      i_cfg = '{`RSS_OSC_RC, 1'b1, 1'b0};
      i_bus = '0;
      do_reset;
      t_power_on;
      t_irq;
      t_clear;
      t_dog;
      t_ost;
      t_bor;
      test_done;
   end
   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      test_done;
   end
endmodule : tb_rss_reset_seq
